// ==== hdl/t16wv_pkg.sv ====
// constants, mode classes and mode decode for the 16-bit timer wave and compare-output block
package t16wv_pkg;

  // ****************************************************************
  // register byte offsets (low address byte only is decoded)
  // ****************************************************************
  localparam logic [7:0] ADDR_WAVE_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CLK_CTRL  = 8'h04;
  localparam logic [7:0] ADDR_COUNTER   = 8'h08;
  localparam logic [7:0] ADDR_CMP_A     = 8'h0c;
  localparam logic [7:0] ADDR_CMP_B     = 8'h10;
  localparam logic [7:0] ADDR_CAPTURE   = 8'h14;
  localparam logic [7:0] ADDR_FLAGS     = 8'h18;
  localparam logic [7:0] ADDR_PIN_CTRL  = 8'h1c;

  // ****************************************************************
  // field positions and write masks
  // ****************************************************************
  localparam int CHA_MODE_LSB   = 6;
  localparam int CHB_MODE_LSB   = 4;
  localparam int WAVE_LOW_LSB   = 0;
  localparam int WAVE_HIGH_LSB  = 3;
  localparam int CLK_SEL_LSB    = 0;
  localparam int OVF_BIT        = 0;
  localparam int PIN_DIR_A_BIT  = 0;
  localparam int PIN_DIR_B_BIT  = 1;
  localparam int PIN_DATA_A_BIT = 2;
  localparam int PIN_DATA_B_BIT = 3;
  localparam logic [7:0] WAVE_CTRL_WMASK = 8'hf3;
  localparam logic [7:0] CLK_CTRL_WMASK  = 8'h1f;
  localparam logic [3:0] PIN_CTRL_WMASK  = 4'hf;

  // ****************************************************************
  // reset values and fixed counter levels
  // ****************************************************************
  localparam logic [7:0]  RST_CTRL8  = 8'h00;
  localparam logic [15:0] RST_WORD16 = 16'h0000;
  localparam logic [3:0]  RST_PIN    = 4'h0;
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_MAX    = 16'hffff;
  localparam logic [15:0] TOP_8BIT   = 16'h00ff;
  localparam logic [15:0] TOP_9BIT   = 16'h01ff;
  localparam logic [15:0] TOP_10BIT  = 16'h03ff;
  localparam logic [15:0] CNT_STEP   = 16'h0001;

  // output-mode field encodings
  localparam logic [1:0] OM_OFF    = 2'h0;
  localparam logic [1:0] OM_TOGGLE = 2'h1;
  localparam logic [1:0] OM_CLEAR  = 2'h2;
  localparam logic [1:0] OM_SET    = 2'h3;

  typedef enum {
    T16WV_NORMAL,
    T16WV_FAST,
    T16WV_PHASE,
    T16WV_PFC,
    T16WV_RSVD
  } t16wv_class_t;

  // ****************************************************************
  // waveform mode decode
  // ****************************************************************
  function automatic t16wv_class_t t16wv_class_of(input logic [3:0] m);
    case (m)
      4'h0, 4'h4, 4'hc:             return T16WV_NORMAL;
      4'h5, 4'h6, 4'h7, 4'he, 4'hf: return T16WV_FAST;
      4'h1, 4'h2, 4'h3, 4'ha, 4'hb: return T16WV_PHASE;
      4'h8, 4'h9:                   return T16WV_PFC;
      default:                      return T16WV_RSVD;
    endcase
  endfunction : t16wv_class_of

  function automatic logic [15:0] t16wv_top_of(input logic [3:0] m,
                                               input logic [15:0] cmp_a,
                                               input logic [15:0] cap);
    case (m)
      4'h1, 4'h5:             return TOP_8BIT;
      4'h2, 4'h6:             return TOP_9BIT;
      4'h3, 4'h7:             return TOP_10BIT;
      4'h4, 4'h9, 4'hb, 4'hf: return cmp_a;
      4'h8, 4'ha, 4'hc, 4'he: return cap;
      default:                return CNT_MAX;
    endcase
  endfunction : t16wv_top_of

  // toggle value is honoured in pwm modes only for these modes
  function automatic logic t16wv_pwm_toggle_ok(input logic [3:0] m);
    case (m)
      4'h8, 4'h9, 4'ha, 4'hb, 4'he, 4'hf: return 1'b1;
      default:                            return 1'b0;
    endcase
  endfunction : t16wv_pwm_toggle_ok

endpackage : t16wv_pkg

// ==== hdl/t16wv_chan.sv ====
// one compare-output channel: applies the output-mode field to match and top events
`timescale 1ns/1ps
module t16wv_chan (
  input  wire logic            hclk,
  input  wire logic            hresetn,
  input  wire logic [1:0]      out_mode,
  input  var t16wv_pkg::t16wv_class_t mode_class,
  input  wire logic            toggle_ok,
  input  wire logic            match,
  input  wire logic            top_evt,
  input  wire logic            count_up,
  input  wire logic            cmp_eq_top,
  output logic                 wave,
  output logic                 drive
);
  import t16wv_pkg::*;

  logic next_wave;

  // ****************************************************************
  // output-mode behaviour per waveform class
  // ****************************************************************
  always_comb
  begin
    next_wave = wave;
    drive     = (out_mode != OM_OFF) && (mode_class != T16WV_RSVD);
    case (mode_class)
      T16WV_NORMAL:
      begin
        if (match)
        begin
          case (out_mode)
            OM_TOGGLE: next_wave = ~wave;
            OM_CLEAR:  next_wave = 1'b0;
            OM_SET:    next_wave = 1'b1;
            default:   next_wave = wave;
          endcase
        end
      end
      T16WV_FAST:
      begin
        if (out_mode == OM_TOGGLE)
        begin
          drive = toggle_ok;
          if (toggle_ok && match)
            next_wave = ~wave;
        end
        else if (out_mode[1])
        begin
          // top action wins; a match equal to top is dropped
          if (top_evt)
            next_wave = (out_mode == OM_CLEAR);
          else if (match && !cmp_eq_top)
            next_wave = (out_mode == OM_SET);
        end
      end
      T16WV_PHASE, T16WV_PFC:
      begin
        if (out_mode == OM_TOGGLE)
        begin
          drive = toggle_ok;
          if (toggle_ok && match)
            next_wave = ~wave;
        end
        else if (out_mode == OM_CLEAR && match)
          next_wave = ~count_up;
        else if (out_mode == OM_SET && match)
          next_wave = count_up;
      end
      default:
        next_wave = wave;
    endcase
  end

  // wave register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wave <= 1'b0;
    else
      wave <= next_wave;
  end

endmodule : t16wv_chan

// ==== hdl/t16wv_top.sv ====
// 16-bit timer waveform-mode decode, counter sequencing and compare-output pins on ahb-lite
//
// Summary of operation
// - channel A mode nonzero takes the pin, except in reserved mode 13 or toggle in modes 1 to 3 and 5 to 7
// - channel B mode nonzero takes the pin, except in reserved mode 13 or toggle in pwm modes
// - output-mode effect depends on waveform class
// - non-pwm: off, toggle, clear, set on match
// - fast pwm toggle only A, modes 14/15
// - fast pwm clear/set on match, opposite at top
// - fast pwm compare equal top: top action only
// - dual-slope toggle only A, modes 8 to 11
// - dual-slope 10: clear up, set down
// - dual-slope 11: set up, clear down
// - mode low bits in ctrl A, high elsewhere
// - top per mode: fixed, compare A, capture
// - phase correct: update at top, overflow bottom
// - phase/freq correct: update, overflow at bottom
// - normal/ctc immediate, max; fast at top
// - dual-slope counts bottom to top to bottom
`timescale 1ns/1ps
module t16wv_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             chan_a_pin_out,
  output logic             chan_a_pin_oe,
  output logic             chan_b_pin_out,
  output logic             chan_b_pin_oe,
  output logic             overflow_flag
);
  import t16wv_pkg::*;

  // ****************************************************************
  // ahb-lite slave
  // ****************************************************************
  logic         wr_pend, rd_pend, next_wr_pend, next_rd_pend, next_hreadyout, accept;
  logic [7:0]   acc_addr, next_acc_addr;
  logic [31:0]  next_hrdata, read_mux;
  logic [7:0]   wave_ctrl, next_wave_ctrl;
  logic [7:0]   clk_ctrl, next_clk_ctrl;
  logic [15:0]  buf_a, next_buf_a;
  logic [15:0]  buf_b, next_buf_b;
  logic [15:0]  capture_value, next_capture_value;
  logic [3:0]   pin_ctrl, next_pin_ctrl;
  logic [15:0]  counter_value, next_counter_value, act_a, next_act_a, act_b, next_act_b;
  logic         count_up, next_count_up, next_overflow_flag;
  logic [3:0]   wave_mode_sel;
  t16wv_class_t mode_class;
  logic [15:0]  top_value;
  logic         tick, at_top, at_bottom, ovf_evt, upd_evt;
  logic         we_wave, we_clk, we_cnt, we_cmp_a, we_cmp_b, we_cap, we_flags, we_pin;
  logic         chan_a_wave_out, chan_b_wave_out, chan_a_drive, chan_b_drive;
  logic         next_a_pin_out, next_a_pin_oe, next_b_pin_out, next_b_pin_oe;

  // reads insert one wait state so a write just before is already visible
  assign accept = hsel && htrans[1] && hready;

  always_comb
  begin
    next_wr_pend   = accept && hwrite;
    next_rd_pend   = accept && !hwrite;
    next_acc_addr  = accept ? haddr[7:0] : acc_addr;
    next_hreadyout = !(accept && !hwrite);
    next_hrdata    = rd_pend ? read_mux : hrdata;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend   <= 1'b0;
      rd_pend   <= 1'b0;
      acc_addr  <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      wr_pend   <= next_wr_pend;
      rd_pend   <= next_rd_pend;
      acc_addr  <= next_acc_addr;
      hrdata    <= next_hrdata;
      hreadyout <= next_hreadyout;
      hresp     <= 1'b0;                 // always okay, unmapped included
    end
  end

  // write strobes, taken in the data phase
  assign we_wave  = wr_pend && (acc_addr == ADDR_WAVE_CTRL);
  assign we_clk   = wr_pend && (acc_addr == ADDR_CLK_CTRL);
  assign we_cnt   = wr_pend && (acc_addr == ADDR_COUNTER);
  assign we_cmp_a = wr_pend && (acc_addr == ADDR_CMP_A);
  assign we_cmp_b = wr_pend && (acc_addr == ADDR_CMP_B);
  assign we_cap   = wr_pend && (acc_addr == ADDR_CAPTURE);
  assign we_flags = wr_pend && (acc_addr == ADDR_FLAGS);
  assign we_pin   = wr_pend && (acc_addr == ADDR_PIN_CTRL);

  // read mux; unmapped addresses read zero
  always_comb
  begin
    read_mux = 32'h0000_0000;
    case (acc_addr)
      ADDR_WAVE_CTRL: read_mux[7:0]  = wave_ctrl & WAVE_CTRL_WMASK;
      ADDR_CLK_CTRL:  read_mux[7:0]  = clk_ctrl;
      ADDR_COUNTER:   read_mux[15:0] = counter_value;
      ADDR_CMP_A:     read_mux[15:0] = buf_a;
      ADDR_CMP_B:     read_mux[15:0] = buf_b;
      ADDR_CAPTURE:   read_mux[15:0] = capture_value;
      ADDR_FLAGS:     read_mux[OVF_BIT] = overflow_flag;
      ADDR_PIN_CTRL:  read_mux[3:0]  = pin_ctrl;
      default:        read_mux = 32'h0000_0000;
    endcase
  end

  // ****************************************************************
  // software registers
  // ****************************************************************
  always_comb
  begin
    next_wave_ctrl     = wave_ctrl;
    next_clk_ctrl      = clk_ctrl;
    next_buf_a         = buf_a;
    next_buf_b         = buf_b;
    next_capture_value = capture_value;
    next_pin_ctrl      = pin_ctrl;
    if (we_wave) next_wave_ctrl = hwdata[7:0] & WAVE_CTRL_WMASK;
    if (we_clk) next_clk_ctrl = hwdata[7:0] & CLK_CTRL_WMASK;
    if (we_cmp_a) next_buf_a = hwdata[15:0];
    if (we_cmp_b) next_buf_b = hwdata[15:0];
    if (we_cap) next_capture_value = hwdata[15:0];
    if (we_pin) next_pin_ctrl = hwdata[3:0] & PIN_CTRL_WMASK;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wave_ctrl     <= RST_CTRL8;
      clk_ctrl      <= RST_CTRL8;
      buf_a         <= RST_WORD16;
      buf_b         <= RST_WORD16;
      capture_value <= RST_WORD16;
      pin_ctrl      <= RST_PIN;
    end
    else
    begin
      wave_ctrl     <= next_wave_ctrl;
      clk_ctrl      <= next_clk_ctrl;
      buf_a         <= next_buf_a;
      buf_b         <= next_buf_b;
      capture_value <= next_capture_value;
      pin_ctrl      <= next_pin_ctrl;
    end
  end

  // ****************************************************************
  // mode decode
  // ****************************************************************
  assign wave_mode_sel = {clk_ctrl[WAVE_HIGH_LSB +: 2],
                          wave_ctrl[WAVE_LOW_LSB +: 2]};
  assign mode_class    = t16wv_class_of(wave_mode_sel);
  assign top_value     = t16wv_top_of(wave_mode_sel, act_a, capture_value);
  // any nonzero clock select runs at the bus clock outside reserved mode 13; prescaling lives elsewhere
  assign tick      = (clk_ctrl[CLK_SEL_LSB +: 3] != 3'h0) &&
                     (mode_class != T16WV_RSVD);
  assign at_top    = (counter_value == top_value);
  assign at_bottom = (counter_value == CNT_BOTTOM);

  // ****************************************************************
  // counter sequencing, buffer update and overflow
  // ****************************************************************
  always_comb
  begin
    next_counter_value = counter_value;
    next_count_up      = count_up;
    ovf_evt            = 1'b0;
    upd_evt            = 1'b0;
    case (mode_class)
      T16WV_NORMAL, T16WV_FAST:
      begin
        next_count_up = 1'b1;
        if (tick)
          next_counter_value = at_top ? CNT_BOTTOM : counter_value + CNT_STEP;
        if (mode_class == T16WV_NORMAL)
          ovf_evt = tick && (counter_value == CNT_MAX);
        else
        begin
          ovf_evt = tick && at_top;
          upd_evt = tick && at_top;
        end
      end
      T16WV_PHASE, T16WV_PFC:
      begin
        if (tick)
        begin
          // turn round at top and at bottom, each held for one tick
          if (count_up && at_top)
          begin
            next_count_up      = 1'b0;
            next_counter_value = counter_value - CNT_STEP;
          end
          else if (!count_up && at_bottom)
          begin
            next_count_up      = 1'b1;
            next_counter_value = counter_value + CNT_STEP;
          end
          else if (count_up)
            next_counter_value = counter_value + CNT_STEP;
          else
            next_counter_value = counter_value - CNT_STEP;
        end
        ovf_evt = tick && !count_up && at_bottom;
        if (mode_class == T16WV_PHASE)
          upd_evt = tick && count_up && at_top;
        else
          upd_evt = tick && !count_up && at_bottom;
      end
      default:
        next_count_up = count_up;
    endcase
    // software write to the counter wins over counting
    if (we_cnt)
      next_counter_value = hwdata[15:0];
  end

  // active compare values: immediate in non-pwm, double buffered otherwise
  always_comb
  begin
    next_act_a = act_a;
    next_act_b = act_b;
    if (mode_class == T16WV_NORMAL || mode_class == T16WV_RSVD || upd_evt)
    begin
      next_act_a = buf_a;
      next_act_b = buf_b;
    end
  end

  // sticky overflow, write one to clear; a new event beats the clear
  assign next_overflow_flag = ovf_evt ||
                              (overflow_flag && !(we_flags && hwdata[OVF_BIT]));

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      counter_value <= RST_WORD16;
      count_up      <= 1'b1;
      act_a         <= RST_WORD16;
      act_b         <= RST_WORD16;
      overflow_flag <= 1'b0;
    end
    else
    begin
      counter_value <= next_counter_value;
      count_up      <= next_count_up;
      act_a         <= next_act_a;
      act_b         <= next_act_b;
      overflow_flag <= next_overflow_flag;
    end
  end

  // ****************************************************************
  // compare-output channels
  // ****************************************************************
  t16wv_chan u_chan_a (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .out_mode   (wave_ctrl[CHA_MODE_LSB +: 2]),
    .mode_class (mode_class),
    .toggle_ok  (t16wv_pwm_toggle_ok(wave_mode_sel)),
    .match      (tick && (counter_value == act_a)),
    .top_evt    (tick && at_top),
    .count_up   (count_up),
    .cmp_eq_top (act_a == top_value),
    .wave       (chan_a_wave_out),
    .drive      (chan_a_drive)
  );

  // channel B never toggles in pwm modes
  t16wv_chan u_chan_b (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .out_mode   (wave_ctrl[CHB_MODE_LSB +: 2]),
    .mode_class (mode_class),
    .toggle_ok  (1'b0),
    .match      (tick && (counter_value == act_b)),
    .top_evt    (tick && at_top),
    .count_up   (count_up),
    .cmp_eq_top (act_b == top_value),
    .wave       (chan_b_wave_out),
    .drive      (chan_b_drive)
  );

  // ****************************************************************
  // pin override and direction
  // ****************************************************************
  // the driver is enabled only by the direction bit, never by the mode field
  always_comb
  begin
    next_a_pin_out = chan_a_drive ? chan_a_wave_out : pin_ctrl[PIN_DATA_A_BIT];
    next_b_pin_out = chan_b_drive ? chan_b_wave_out : pin_ctrl[PIN_DATA_B_BIT];
    next_a_pin_oe  = pin_ctrl[PIN_DIR_A_BIT];
    next_b_pin_oe  = pin_ctrl[PIN_DIR_B_BIT];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      chan_a_pin_out <= 1'b0;
      chan_a_pin_oe  <= 1'b0;
      chan_b_pin_out <= 1'b0;
      chan_b_pin_oe  <= 1'b0;
    end
    else
    begin
      chan_a_pin_out <= next_a_pin_out;
      chan_a_pin_oe  <= next_a_pin_oe;
      chan_b_pin_out <= next_b_pin_out;
      chan_b_pin_oe  <= next_b_pin_oe;
    end
  end

endmodule : t16wv_top

// ==== testbench/t16wv_sva.sv ====
// concurrent checks of bus timing and pin hand-over for the timer wave block
`timescale 1ns/1ps
module t16wv_sva
  import t16wv_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        chan_a_pin_out,
  input wire logic        chan_a_pin_oe,
  input wire logic        chan_b_pin_out,
  input wire logic        chan_b_pin_oe,
  input wire logic        overflow_flag
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic       taken, quiet, ap_wr;
  logic [7:0] ap_addr, sh_wave, sh_clk;
  logic [3:0] sh_pin, wm;
  logic [1:0] settle;

  assign taken = hsel && htrans[1] && hready;
  assign quiet = (settle == 2'h3);
  assign wm    = {sh_clk[4:3], sh_wave[1:0]};

  // shadow of control writes; pins are judged only once a write has settled
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      ap_wr   <= 1'b0;
      ap_addr <= 8'h00;
      sh_wave <= 8'h00;
      sh_clk  <= 8'h00;
      sh_pin  <= 4'h0;
      settle  <= 2'h0;
    end
    else
    begin
      ap_wr   <= taken && hwrite;
      ap_addr <= haddr[7:0];
      settle  <= ap_wr ? 2'h0 : (quiet ? settle : settle + 2'h1);
      if (ap_wr && ap_addr == ADDR_WAVE_CTRL)
        sh_wave <= hwdata[7:0] & WAVE_CTRL_WMASK;
      if (ap_wr && ap_addr == ADDR_CLK_CTRL)
        sh_clk <= hwdata[7:0] & CLK_CTRL_WMASK;
      if (ap_wr && ap_addr == ADDR_PIN_CTRL)
        sh_pin <= hwdata[3:0];
    end

  a_read_wait: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (taken && hwrite |=> hreadyout)
    else $error("write stalled");
  a_ctrl_readback: assert property (taken && !hwrite && haddr[7:0] == ADDR_WAVE_CTRL
    |=> ##1 hrdata == {24'h0, sh_wave})
    else $error("control readback wrong");
  a_dir_pins: assert property (quiet |-> {chan_b_pin_oe, chan_a_pin_oe} == sh_pin[1:0])
    else $error("pin enable not from direction bits");
  a_a_off: assert property (quiet && sh_wave[7:6] == 2'h0 |-> chan_a_pin_out == sh_pin[2])
    else $error("pin a not port data");
  a_b_off: assert property (quiet && sh_wave[5:4] == 2'h0 |-> chan_b_pin_out == sh_pin[3])
    else $error("pin b not port data");
  a_fast_tog_b: assert property (quiet && sh_wave[5:4] == 2'h1
    && wm inside {4'h5, 4'h6, 4'h7, 4'he, 4'hf} |-> chan_b_pin_out == sh_pin[3])
    else $error("fast toggle b connected");
  a_dual_tog_a: assert property (quiet && sh_wave[7:6] == 2'h1
    && wm inside {4'h1, 4'h2, 4'h3} |-> chan_a_pin_out == sh_pin[2])
    else $error("dual toggle a connected");
  a_rsvd_idle: assert property (quiet && wm == 4'hd
    |-> {chan_b_pin_out, chan_a_pin_out} == sh_pin[3:2])
    else $error("reserved mode drives pins");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
endmodule : t16wv_sva

bind t16wv_top t16wv_sva u_sva (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .chan_a_pin_out(chan_a_pin_out),
  .chan_a_pin_oe(chan_a_pin_oe), .chan_b_pin_out(chan_b_pin_out),
  .chan_b_pin_oe(chan_b_pin_oe), .overflow_flag(overflow_flag));

// ==== testbench/t16wv_top_tb.sv ====
// self-checking bench for the timer wave and compare-output block
`timescale 1ns/1ps
module t16wv_top_tb;
  import t16wv_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        a_out, a_oe, b_out, b_oe, ovf;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          failures = 0;
  int          samples_checked = 0;
  wire logic   hready = hreadyout;

  t16wv_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .chan_a_pin_out(a_out),
    .chan_a_pin_oe(a_oe), .chan_b_pin_out(b_out), .chan_b_pin_oe(b_oe), .overflow_flag(ovf));

  always #5 hclk = ~hclk;

  task automatic tally_and_finish;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // a stuck slave would hang the run, so the wait is bounded
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        failures++;
        tally_and_finish;
      end
      @(posedge hclk);
    end
  endtask : wait_rdy

  // one single word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy;
    rd = hrdata;
  endtask : bus

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc

  // counter stopped before the flag is cleared, so no new event races the check
  task automatic clear_ovf;
    bus(1'b1, ADDR_CLK_CTRL, 32'h0);
    bus(1'b1, ADDR_FLAGS, 32'h1);
    repeat (2) @(posedge hclk);
    chk(ovf, 1'b0);
  endtask : clear_ovf

  // load with the counter stopped, run long enough for buffered compares, count high cycles
  task automatic run_case(input logic [3:0] m, input logic [1:0] ma, mb,
                          input logic [15:0] ca, cb, input int n, ea, eb);
    int ha, hb;
    ha = 0;
    hb = 0;
    bus(1'b1, ADDR_CLK_CTRL, {27'h0, m[3:2], 3'h0});
    bus(1'b1, ADDR_COUNTER, 32'h0);
    bus(1'b1, ADDR_CMP_A, {16'h0, ca});
    bus(1'b1, ADDR_CMP_B, {16'h0, cb});
    bus(1'b1, ADDR_WAVE_CTRL, {24'h0, ma, mb, 2'h0, m[1:0]});
    bus(1'b1, ADDR_CLK_CTRL, {27'h0, m[3:2], 3'h1});
    repeat (2100) @(posedge hclk);
    repeat (n)
    begin
      @(posedge hclk);
      ha += a_out;
      hb += b_out;
    end
    chk(ha, ea);
    chk(hb, eb);
  endtask : run_case

  // reset, register map, then several waveform cases in each non-reserved mode class
  initial
  begin
    hclk    = 1'b0;
    hresetn = 1'b0;
    hsel    = 1'b0;
    hwrite  = 1'b0;
    htrans  = 2'h0;
    hsize   = 3'h2;
    haddr   = 32'h0;
    hwdata  = 32'h0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 10; i++)
      rdc(8'(4 * i), 32'h0);
    bus(1'b1, ADDR_WAVE_CTRL, 32'hff);
    rdc(ADDR_WAVE_CTRL, 32'hf3);
    bus(1'b1, ADDR_WAVE_CTRL, 32'hf1);
    bus(1'b1, ADDR_CLK_CTRL, 32'hf8);
    rdc(ADDR_CLK_CTRL, 32'h18);
    bus(1'b1, ADDR_PIN_CTRL, 32'hc);
    repeat (4) @(posedge hclk);
    chk({b_out, a_out, b_oe, a_oe}, 4'hc);
    bus(1'b1, ADDR_CAPTURE, 32'hff);
    bus(1'b1, ADDR_PIN_CTRL, 32'h3);
    run_case(4'h4, 2'h3, 2'h2, 16'h10, 16'h08, 340, 340, 0);
    run_case(4'h4, 2'h1, 2'h1, 16'h10, 16'h08, 340, 170, 170);
    chk(ovf, 1'b0);
    run_case(4'h5, 2'h2, 2'h3, 16'h40, 16'h40, 512, 130, 382);
    chk(ovf, 1'b1);
    clear_ovf;
    run_case(4'h5, 2'h3, 2'h2, 16'h40, 16'hff, 512, 382, 512);
    run_case(4'h5, 2'h1, 2'h1, 16'h40, 16'h40, 512, 0, 0);
    run_case(4'h7, 2'h2, 2'h0, 16'h40, 16'h40, 1024, 65, 0);
    run_case(4'he, 2'h2, 2'h0, 16'h40, 16'h40, 512, 130, 0);
    run_case(4'hf, 2'h1, 2'h1, 16'h20, 16'h10, 132, 66, 0);
    clear_ovf;
    run_case(4'h1, 2'h2, 2'h3, 16'h40, 16'h40, 1020, 256, 764);
    chk(ovf, 1'b1);
    run_case(4'h1, 2'h1, 2'h0, 16'h40, 16'h40, 1020, 0, 0);
    run_case(4'hb, 2'h1, 2'h1, 16'h20, 16'h10, 256, 128, 0);
    run_case(4'h9, 2'h1, 2'h2, 16'h80, 16'h40, 512, 256, 256);
    run_case(4'h8, 2'h2, 2'h3, 16'h40, 16'h40, 1020, 256, 764);
    run_case(4'hc, 2'h1, 2'h3, 16'h40, 16'h10, 512, 256, 512);
    tally_and_finish;
  end
endmodule : t16wv_top_tb
